/* File: bench/scpm_top_test.sv */
// self-checking bench for the clock/power-mode block, driven over apb
`timescale 1ns/1ns
`include "scpm_cfg.svh"
module scpm_top_test;
	import scpm_pkg::*;
	localparam logic [11:0] sys_a = `SCPM_OFF_SYS_CLK_CTRL;
	localparam logic [11:0] fast_a = `SCPM_OFF_FAST_OSC_CTRL;
	logic clk, rst_b, psel, penable, pwrite, halt_req, wake_req;
	logic wdt_enable, wdt_timeout, clr_wdt, fast_osc_tick, slow_osc_tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, fast_osc_run, slow_osc_run, sys_clk_en, cpu_clk_en;
	logic fast_clk_en, sub_clk_en, wdt_clk_en, cpu_halted, wdt_counter_clr;
	logic wdt_count_en, power_down_flag, watchdog_timeout_flag, er;
	scpm_pmode_t power_mode;
	int err_total, check_count, tk, cf, cs, cc, cy, ch, cw, n;
	logic [1:0] kp_tab [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
	logic [2:0] pm_tab [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1};

	scpm_top dut_u (
		.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .halt_req, .wake_req, .wdt_enable, .wdt_timeout, .clr_wdt,
		.fast_osc_tick, .slow_osc_tick, .fast_osc_run, .slow_osc_run, .sys_clk_en,
		.cpu_clk_en, .fast_clk_en, .sub_clk_en, .wdt_clk_en, .cpu_halted,
		.wdt_counter_clr, .wdt_count_en, .power_down_flag, .watchdog_timeout_flag,
		.power_mode
	);

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// oscillators only tick while the block asks them to run
	always @(posedge clk) begin
		tk <= tk + 1;
		fast_osc_tick <= (fast_osc_run === 1'h1) && tk[0];
		slow_osc_tick <= (slow_osc_run === 1'h1) && (tk[3:0] == 4'hf);
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	task close_out;
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			chk("pready", 1, pready);
			close_out;
		end
	endtask

	task wait_stable;
		int k;
		k = 0;
		do begin
			apb(1'h0, fast_a, 32'h0);
			k++;
		end while (rd[1] !== 1'h1 && k < 300);
		chk("stable_rd", 32'h3, rd);
		if (rd[1] !== 1'h1)
			close_out;
	endtask

	task count_win(input int len);
		cf = 0;
		cs = 0;
		cc = 0;
		cy = 0;
		ch = 0;
		cw = 0;
		repeat (len) begin
			@(negedge clk);
			cf += (fast_clk_en === 1'h1);
			cs += (sub_clk_en === 1'h1);
			cc += (cpu_clk_en === 1'h1);
			cy += (sys_clk_en === 1'h1);
			ch += (cpu_halted === 1'h1);
			cw += (wdt_clk_en === 1'h1);
		end
	endtask

	task wait_wake;
		n = 0;
		while (cpu_halted !== 1'h0 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk("woke", 0, cpu_halted);
		if (cpu_halted !== 1'h0)
			close_out;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		chk("run_limit", 0, 1);
		close_out;
	end

	initial begin
		rst_b = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		halt_req = 1'h0;
		wake_req = 1'h0;
		wdt_enable = 1'h0;
		wdt_timeout = 1'h0;
		clr_wdt = 1'h0;
		fast_osc_tick = 1'h0;
		slow_osc_tick = 1'h0;
		tk = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, sys_a, 32'h0);
		chk("sys_reset", 32'h0, rd);
		apb(1'h0, fast_a, 32'h0);
		chk("fast_reset", 32'h1, rd);
		chk("fast_run_reset", 1, fast_osc_run);
		apb(1'h1, sys_a, 32'hffff_ff1f);
		apb(1'h0, sys_a, 32'h0);
		chk("sys_unused", 32'h3, rd);
		apb(1'h1, 12'h008, 32'hffff_ffff);
		chk("bad_wr_err", 1, er);
		apb(1'h0, 12'h008, 32'h0);
		chk("bad_rd_err", 1, er);
		chk("bad_rd_data", 32'h0, rd);
		wait_stable;
		@(posedge clk);
		wdt_timeout <= 1'h1;
		@(posedge clk);
		wdt_timeout <= 1'h0;
		@(negedge clk);
		chk("tof_set", 1, watchdog_timeout_flag);
		for (int i = 0; i < 5; i++) begin
			wdt_enable <= (i == 4);
			apb(1'h1, sys_a, {30'h0, kp_tab[i]});
			@(posedge clk);
			halt_req <= 1'h1;
			@(posedge clk);
			halt_req <= 1'h0;
			@(negedge clk);
			chk("halted", 1, cpu_halted);
			chk("pdf", 1, power_down_flag);
			chk("tof", 0, watchdog_timeout_flag);
			chk("wdt_clr", 1, wdt_counter_clr);
			chk("wdt_cnt_en", (i == 4), wdt_count_en);
			chk("pmode", pm_tab[i], power_mode);
			repeat (3) @(negedge clk);
			chk("wdt_clr_pulse", 0, wdt_counter_clr);
			chk("fast_run", kp_tab[i][1], fast_osc_run);
			// the slow oscillator may still serve the watchdog with fast kept only
			if (kp_tab[i] != 2'h2)
				chk("slow_run", kp_tab[i][0] | (i == 4), slow_osc_run);
			count_win(64);
			chk("cpu_clk_off", 0, cc);
			chk("fast_clk", kp_tab[i][1], cf != 0);
			chk("sub_clk", kp_tab[i][0], cs != 0);
			chk("held", 64, ch);
			if (i == 4)
				chk("wdt_clk", 1, cw != 0);
			@(posedge clk);
			wake_req <= 1'h1;
			@(posedge clk);
			wake_req <= 1'h0;
			wait_wake;
			count_win(64);
			chk("cpu_clk_back", 1, cc != 0);
			chk("pmode_run", 0, power_mode);
		end
		@(posedge clk);
		clr_wdt <= 1'h1;
		@(posedge clk);
		clr_wdt <= 1'h0;
		@(negedge clk);
		chk("pdf_clr", 0, power_down_flag);
		// divided counts land within one of the ideal figure, phase is unknown
		for (int s = 0; s < 8; s++) begin
			if (s == 7)
				repeat (2600) @(posedge clk);
			apb(1'h1, sys_a, {24'h0, s[2:0], 5'h0});
			repeat (140) @(posedge clk);
			count_win(256);
			n = (s == 7) ? 16 : (128 >> s);
			chk("sys_clk_rate", 1, cy + 1 >= n && cy <= n + 1);
		end
		apb(1'h1, fast_a, 32'h0);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("fast_stop", 0, fast_osc_run);
		apb(1'h1, fast_a, 32'h1);
		apb(1'h0, fast_a, 32'h0);
		chk("stable_clr", 32'h1, rd);
		wait_stable;
		chk("fast_restart", 1, fast_osc_run);
		close_out;
	end
endmodule

/* File: inc/scpm_cfg.svh */
// offsets, field positions, reset values and timing counts of the clock/power-mode block
`ifndef SCPM_CFG_SVH
`define SCPM_CFG_SVH

`define SCPM_ADDR_W 12
`define SCPM_OFF_SYS_CLK_CTRL 12'h000
`define SCPM_OFF_FAST_OSC_CTRL 12'h004

`define SCPM_SEL_HI 7
`define SCPM_SEL_LO 5
`define SCPM_FAST_KEEP_BIT 1
`define SCPM_SLOW_KEEP_BIT 0
`define SCPM_STABLE_BIT 1
`define SCPM_ENABLE_BIT 0

`define SCPM_SEL_RST 3'h0
`define SCPM_SEL_SLOW 3'h7
`define SCPM_KEEP_RST 1'h0
`define SCPM_FAST_EN_RST 1'h1

`define SCPM_CLK_MHZ 25
`define SCPM_FAST_SETTLE_NS 16000
`define SCPM_SLOW_SETTLE_NS 100000
`define SCPM_FAST_SETTLE_CYC ((`SCPM_FAST_SETTLE_NS * `SCPM_CLK_MHZ + 999) / 1000)
`define SCPM_SLOW_SETTLE_CYC ((`SCPM_SLOW_SETTLE_NS * `SCPM_CLK_MHZ + 999) / 1000)
`define SCPM_SETTLE_W 12

`endif

/* File: inc/scpm_pkg.sv */
// types shared by the clock/power-mode block
package scpm_pkg;
	typedef enum logic [2:0] {
		SCPM_RUN = 3'b001,
		SCPM_HALT = 3'b010,
		SCPM_WAKE = 3'b100
	} scpm_state_t;

	typedef enum logic [2:0] {
		SCPM_PM_ACTIVE = 3'h0,
		SCPM_PM_SLEEP = 3'h1,
		SCPM_PM_IDLE_SLOW_ONLY = 3'h2,
		SCPM_PM_IDLE_BOTH_CLOCKS = 3'h3,
		SCPM_PM_IDLE_FAST_ONLY = 3'h4
	} scpm_pmode_t;
endpackage

/* File: verilog/scpm_settle_timer.sv */
// oscillator settling timer: stable flag rises a fixed count after the oscillator starts
`timescale 1ns/1ns
`include "scpm_cfg.svh"
module scpm_settle_timer #(
	parameter logic [`SCPM_SETTLE_W-1:0] SETTLE_CYC = 12'h001
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic osc_run,
	input wire logic restart,
	output logic stable
);
	logic [`SCPM_SETTLE_W-1:0] cnt_q;

	// restart drops the flag at once, even while the oscillator keeps running
	always_ff @(posedge clk) begin
		if (!rst_b || !osc_run || restart) begin
			cnt_q <= '0;
		end else if (cnt_q != SETTLE_CYC) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || !osc_run || restart) begin
			stable <= 1'b0;
		end else if (cnt_q == SETTLE_CYC) begin
			stable <= 1'b1;
		end
	end
endmodule

/* File: verilog/scpm_top.sv */
// system clock selection, oscillator gating and power-down mode control with apb registers
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "scpm_cfg.svh"

// Notes on behaviour
// - select codes pick fast divisor or slow clock
// - slow mode runs from the slow oscillator
// - sleep stops all clocks except watchdog's
// - idle_slow_only keeps slow clock, stops fast
// - idle_both_clocks keeps fast and slow clocks
// - idle_fast_only keeps fast, stops slow clock
// - halt sets power-down, clears timeout flag
// - halt clears watchdog counter, enable decides counting
// - halt freezes cpu state and execution
// - enable rising clears stable flag, settles later
// - fast enable bit starts/stops oscillator, resets 1; ignored in halt and while a fast source clocks the cpu in run
// - slow mode fast clock follows enable bit
// - sleep keeps slow oscillator only with watchdog
// - switch to slow waits for slow stable
// - select and keep bits reset 0, unused read 0
module scpm_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SCPM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic halt_req,
	input wire logic wake_req,
	input wire logic wdt_enable,
	input wire logic wdt_timeout,
	input wire logic clr_wdt,
	input wire logic fast_osc_tick,
	input wire logic slow_osc_tick,
	output logic fast_osc_run,
	output logic slow_osc_run,
	output logic sys_clk_en,
	output logic cpu_clk_en,
	output logic fast_clk_en,
	output logic sub_clk_en,
	output logic wdt_clk_en,
	output logic cpu_halted,
	output logic wdt_counter_clr,
	output logic wdt_count_en,
	output logic power_down_flag,
	output logic watchdog_timeout_flag,
	output scpm_pkg::scpm_pmode_t power_mode
);
	import scpm_pkg::*;

	function automatic logic sel_is_slow(input logic [2:0] sel);
		sel_is_slow = (sel == `SCPM_SEL_SLOW);
	endfunction

	// low bits of the fast tick counter that must be all ones for a divided pulse
	function automatic logic [5:0] div_mask(input logic [2:0] sel);
		logic [6:0] m;
		m = 7'h00;
		m = (7'h01 << sel) - 7'h01;
		div_mask = m[5:0];
	endfunction

	scpm_state_t state_q;
	logic [2:0] sys_clk_select_q;
	logic fast_osc_keep_in_halt_q;
	logic slow_osc_keep_in_halt_q;
	logic fast_osc_enable_q;
	logic [2:0] active_sel_q;
	logic [5:0] div_cnt_q;
	logic fast_restart_q;
	logic fast_osc_stable_flag;
	logic slow_stable;
	logic wr_take, rd_take, addr_ok;
	logic fast_run_d, slow_run_d, sub_run_d, sys_src_on, sys_tick;

	assign addr_ok = (paddr == `SCPM_OFF_SYS_CLK_CTRL) || (paddr == `SCPM_OFF_FAST_OSC_CTRL);
	assign wr_take = psel && penable && pready && pwrite;
	assign rd_take = psel && penable && !pready;

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && penable && !pready && !addr_ok;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (rd_take && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (paddr == `SCPM_OFF_SYS_CLK_CTRL) begin
				prdata[`SCPM_SEL_HI:`SCPM_SEL_LO] <= sys_clk_select_q;
				prdata[`SCPM_FAST_KEEP_BIT] <= fast_osc_keep_in_halt_q;
				prdata[`SCPM_SLOW_KEEP_BIT] <= slow_osc_keep_in_halt_q;
			end else if (paddr == `SCPM_OFF_FAST_OSC_CTRL) begin
				prdata[`SCPM_STABLE_BIT] <= fast_osc_stable_flag;
				prdata[`SCPM_ENABLE_BIT] <= fast_osc_enable_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sys_clk_select_q <= `SCPM_SEL_RST;
			fast_osc_keep_in_halt_q <= `SCPM_KEEP_RST;
			slow_osc_keep_in_halt_q <= `SCPM_KEEP_RST;
		end else if (wr_take && paddr == `SCPM_OFF_SYS_CLK_CTRL) begin
			sys_clk_select_q <= pwdata[`SCPM_SEL_HI:`SCPM_SEL_LO];
			fast_osc_keep_in_halt_q <= pwdata[`SCPM_FAST_KEEP_BIT];
			slow_osc_keep_in_halt_q <= pwdata[`SCPM_SLOW_KEEP_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fast_osc_enable_q <= `SCPM_FAST_EN_RST;
		end else if (wr_take && paddr == `SCPM_OFF_FAST_OSC_CTRL) begin
			fast_osc_enable_q <= pwdata[`SCPM_ENABLE_BIT];
		end
	end

	// a write of 1 restarts settling only when the enable bit was 0, so the flag reads 0 first
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fast_restart_q <= 1'b0;
		end else begin
			fast_restart_q <= wr_take && paddr == `SCPM_OFF_FAST_OSC_CTRL &&
				pwdata[`SCPM_ENABLE_BIT] && !fast_osc_enable_q;
		end
	end

	scpm_settle_timer #(
		.SETTLE_CYC(`SCPM_SETTLE_W'(`SCPM_FAST_SETTLE_CYC))
	) u_fast_settle (
		.clk(clk),
		.rst_b(rst_b),
		.osc_run(fast_osc_run),
		.restart(fast_restart_q),
		.stable(fast_osc_stable_flag)
	);

	scpm_settle_timer #(
		.SETTLE_CYC(`SCPM_SETTLE_W'(`SCPM_SLOW_SETTLE_CYC))
	) u_slow_settle (
		.clk(clk),
		.rst_b(rst_b),
		.osc_run(slow_osc_run),
		.restart(1'b0),
		.stable(slow_stable)
	);

	// mode machine; halt while waking is ignored, wake while running is ignored
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= SCPM_RUN;
		end else begin
			case (state_q)
				SCPM_RUN: begin
					if (halt_req) begin
						state_q <= SCPM_HALT;
					end
				end
				SCPM_HALT: begin
					if (wake_req) begin
						state_q <= SCPM_WAKE;
					end
				end
				SCPM_WAKE: begin
					// resume only once the selected source is settled
					if (sel_is_slow(active_sel_q) ? slow_stable : fast_osc_stable_flag) begin
						state_q <= SCPM_RUN;
					end
				end
				default: begin
					state_q <= SCPM_RUN;
				end
			endcase
		end
	end

	// source switch: to slow only when settled, to fast at once
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			active_sel_q <= `SCPM_SEL_RST;
		end else if (sel_is_slow(sys_clk_select_q)) begin
			if (slow_stable) begin
				active_sel_q <= sys_clk_select_q;
			end
		end else begin
			active_sel_q <= sys_clk_select_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_cnt_q <= 6'h00;
		end else if (fast_osc_tick && fast_osc_run) begin
			div_cnt_q <= div_cnt_q + 6'h01;
		end
	end

	always_comb begin
		fast_run_d = 1'b1;
		slow_run_d = 1'b1;
		sub_run_d = 1'b1;
		if (state_q == SCPM_HALT) begin
			fast_run_d = fast_osc_keep_in_halt_q;
			sub_run_d = slow_osc_keep_in_halt_q;
			slow_run_d = slow_osc_keep_in_halt_q || wdt_enable;
		end else if (sel_is_slow(active_sel_q)) begin
			fast_run_d = fast_osc_enable_q;
		end else begin
			// an active fast source cannot be cut under the cpu
			fast_run_d = fast_osc_enable_q || (state_q == SCPM_RUN);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fast_osc_run <= `SCPM_FAST_EN_RST;
			slow_osc_run <= 1'b1;
			sub_clk_en <= 1'b0;
			fast_clk_en <= 1'b0;
			wdt_clk_en <= 1'b0;
		end else begin
			fast_osc_run <= fast_run_d;
			slow_osc_run <= slow_run_d;
			sub_clk_en <= slow_osc_tick && slow_osc_run && sub_run_d;
			fast_clk_en <= fast_osc_tick && fast_osc_run && fast_run_d;
			wdt_clk_en <= slow_osc_tick && slow_osc_run;
		end
	end

	assign sys_src_on = sel_is_slow(active_sel_q) ? sub_run_d : fast_run_d;
	assign sys_tick = sel_is_slow(active_sel_q) ? (slow_osc_tick && slow_osc_run) :
		(fast_osc_tick && fast_osc_run && ((div_cnt_q & div_mask(active_sel_q)) ==
		div_mask(active_sel_q)));

	// enables are whole-cycle pulses, so a source change never gives a runt
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sys_clk_en <= 1'b0;
			cpu_clk_en <= 1'b0;
		end else begin
			sys_clk_en <= sys_tick && sys_src_on && state_q != SCPM_WAKE;
			cpu_clk_en <= sys_tick && state_q == SCPM_RUN && !halt_req;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cpu_halted <= 1'b0;
		end else begin
			cpu_halted <= (state_q == SCPM_RUN) ? halt_req : (state_q != SCPM_WAKE) ||
				!(sel_is_slow(active_sel_q) ? slow_stable : fast_osc_stable_flag);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wdt_counter_clr <= 1'b0;
			wdt_count_en <= 1'b0;
		end else begin
			wdt_counter_clr <= halt_req && state_q == SCPM_RUN;
			wdt_count_en <= wdt_enable;
		end
	end

	// set wins over clear on both flags
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			power_down_flag <= 1'b0;
		end else if (halt_req && state_q == SCPM_RUN) begin
			power_down_flag <= 1'b1;
		end else if (clr_wdt) begin
			power_down_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			watchdog_timeout_flag <= 1'b0;
		end else if (wdt_timeout) begin
			watchdog_timeout_flag <= 1'b1;
		end else if (halt_req && state_q == SCPM_RUN) begin
			watchdog_timeout_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			power_mode <= SCPM_PM_ACTIVE;
		end else if (halt_req && state_q == SCPM_RUN) begin
			case ({fast_osc_keep_in_halt_q, slow_osc_keep_in_halt_q})
				2'b00: power_mode <= SCPM_PM_SLEEP;
				2'b01: power_mode <= SCPM_PM_IDLE_SLOW_ONLY;
				2'b11: power_mode <= SCPM_PM_IDLE_BOTH_CLOCKS;
				2'b10: power_mode <= SCPM_PM_IDLE_FAST_ONLY;
				default: power_mode <= SCPM_PM_SLEEP;
			endcase
		end else if (state_q == SCPM_RUN) begin
			power_mode <= SCPM_PM_ACTIVE;
		end
	end

	a_halt_flags: assert property (@(posedge clk) disable iff (!rst_b)
		(halt_req && state_q == SCPM_RUN && !wdt_timeout) |=>
		(power_down_flag && !watchdog_timeout_flag && wdt_counter_clr))
		else $error("halt did not set power-down and clear timeout");

	a_sleep_clocks: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == SCPM_HALT && !fast_osc_keep_in_halt_q && !slow_osc_keep_in_halt_q)
		##1 (state_q == SCPM_HALT) |-> (!fast_osc_run && !sub_clk_en && !cpu_clk_en))
		else $error("clock running in sleep");

	a_sleep_wdt_osc: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == SCPM_HALT && !slow_osc_keep_in_halt_q) |=> (slow_osc_run == $past(wdt_enable)))
		else $error("slow oscillator not following watchdog enable in sleep");

	a_idle_fast: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == SCPM_HALT && fast_osc_keep_in_halt_q) |=> fast_osc_run)
		else $error("fast oscillator stopped in idle with fast keep");

	a_idle_slow_only: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == SCPM_HALT && !fast_osc_keep_in_halt_q && slow_osc_keep_in_halt_q)
		|=> (!fast_osc_run && slow_osc_run))
		else $error("wrong oscillators in idle_slow_only");

	a_halt_no_cpu: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == SCPM_HALT) [*2] |-> !cpu_clk_en && cpu_halted)
		else $error("cpu clocked during power-down");

	a_slow_switch: assert property (@(posedge clk) disable iff (!rst_b)
		(sel_is_slow(active_sel_q) && !$past(sel_is_slow(active_sel_q))) |-> $past(slow_stable))
		else $error("switched to slow clock before it settled");

	a_stable_clear: assert property (@(posedge clk) disable iff (!rst_b)
		fast_restart_q |=> !fast_osc_stable_flag ##1 !fast_osc_stable_flag)
		else $error("stable flag not cleared on enable");

	a_slow_fast_en: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == SCPM_RUN && sel_is_slow(active_sel_q)) |=> fast_osc_run == $past(fast_osc_enable_q))
		else $error("fast oscillator not following enable in slow mode");

	a_wake_stable: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == SCPM_WAKE && !sel_is_slow(active_sel_q) && !fast_osc_stable_flag)
		|=> state_q != SCPM_RUN)
		else $error("woke onto an unsettled fast clock");

	c_sleep: cover property (@(posedge clk) disable iff (!rst_b)
		state_q == SCPM_HALT && power_mode == SCPM_PM_SLEEP ##1 state_q == SCPM_WAKE);
	c_slow_mode: cover property (@(posedge clk) disable iff (!rst_b)
		sel_is_slow(active_sel_q) && cpu_clk_en);
	c_restart: cover property (@(posedge clk) disable iff (!rst_b)
		fast_restart_q ##[1:500] fast_osc_stable_flag);
endmodule
